// ---- stfs_pkg.sv ----
// stfs_pkg: constants for the transmit fifo and channel status block.
// assumes a single mclk domain; byte addresses on a 7-bit address bus.
package stfs_pkg;
  localparam logic [6:0] ADDR_FIFO_A   = 7'h00;
  localparam logic [6:0] ADDR_STATUS_A = 7'h20;
  localparam logic [6:0] ADDR_FIFO_B   = 7'h40;
  localparam logic [6:0] ADDR_STATUS_B = 7'h60;
  localparam logic [6:0] ADDR_WIN_MASK = 7'h60;
  localparam logic [7:0] STATUS_RESET  = 8'h40;
  localparam int BIT_OVF   = 7;
  localparam int BIT_WREN  = 6;
  localparam int BIT_RXNE  = 5;
  localparam int BIT_SYNC  = 4;
  localparam int BIT_CEC   = 2;
  localparam int BIT_CTS   = 1;
  localparam int HALF_BYTES = 32;
  localparam int WORD_BLOCK = 16;
  localparam int PTR_W      = 6;
  // longest command time: 2.5 transmit clock periods, counted in half periods
  localparam int CMD_HALF_PERIODS = 5;
  typedef enum logic [1:0] {STFS_IDLE, STFS_BLOCK, STFS_WAIT} stfs_dma_t;
endpackage

// ---- stfs_shifter.sv ----
// stfs_shifter: serialises one byte at a time, lsb first.
// assumes tx_clk_en marks one transmit bit period in the mclk domain.
`timescale 1ns/1ps
module stfs_shifter (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       tx_clk_en,
  input  wire logic       load,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            txd
);
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic       txd_q, txd_d;

  always_comb begin
    sh_d  = sh_q;
    cnt_d = cnt_q;
    txd_d = txd_q;
    if (load && cnt_q == 4'h0) begin
      sh_d  = data;
      cnt_d = 4'h8;
    end else if (tx_clk_en && cnt_q != 4'h0) begin
      txd_d = sh_q[0]; // RL1
      sh_d  = {1'b0, sh_q[7:1]};
      cnt_d = cnt_q - 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh_q  <= 8'h00;
      cnt_q <= 4'h0;
      txd_q <= 1'b1;
    end else begin
      sh_q  <= sh_d;
      cnt_q <= cnt_d;
      txd_q <= txd_d;
    end
  end

  assign busy = (cnt_q != 4'h0);
  assign txd  = txd_q;
endmodule // stfs_shifter

// ---- stfs_core.sv ----
// stfs_core: one channel's transmit fifo, dma block requests and status.
// assumes synchronous bus strobes on mclk; channel selected by addr bit 6.
// Function
// RL1: byte or word writes, sent lsb first
// RL2: dma_select clear means interrupt mode
// RL3: host writes max 32 bytes per ready
// RL4: host loads byte count before dma
// RL5: odd count with words drops last byte
// RL6: dma requests full blocks then remainder
// RL7: whole 32-byte window hits same location
// RL8: overflow set beyond 32 written bytes
// RL9: overflow cleared by reset or handover
// RL10: write enable shows host may write
// RL11: rx not empty status bit 5
// RL12: resync search clears sync bit
// RL13: sync char sets sync immediately
// RL14: command idle lets host write
// RL15: busy command blocks new command
// RL16: command busy at most 2.5 tx periods
// RL17: power-down keeps command busy
// RL18: cts reflected inverted, bits 3,0 zero
`timescale 1ns/1ps
module stfs_core #(
  parameter logic CHANNEL_B = 1'b0
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [6:0]  addr,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        word_mode,
  input  wire logic [15:0] wdata,
  output logic [7:0]       rdata,
  input  wire logic        dma_select,
  input  wire logic [11:0] tx_byte_count,
  input  wire logic        transmit_frame_cmd,
  input  wire logic        tx_reset_cmd,
  input  wire logic        resync_search_cmd,
  input  wire logic        cmd_write,
  input  wire logic        power_down,
  input  wire logic        tx_clk_en,
  input  wire logic        rx_fifo_not_empty,
  input  wire logic        sync_char_found,
  input  wire logic        cts_n,
  output logic             tx_pool_ready_irq,
  output logic             dma_request,
  output logic             txd
);
  localparam int DEPTH = 2 * stfs_pkg::HALF_BYTES;

  logic [7:0] mem_q [DEPTH];
  logic [stfs_pkg::PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [stfs_pkg::PTR_W:0]   cnt_q, cnt_d;
  logic [stfs_pkg::PTR_W:0]   acc_q, acc_d;
  logic       ovf_q, ovf_d, sync_q, sync_d, cec_q, cec_d, rdy_q, rdy_d;
  logic [2:0] ceccnt_q, ceccnt_d;
  logic [11:0] rem_q, rem_d;
  logic [5:0]  blk_q, blk_d;
  stfs_pkg::stfs_dma_t st_q, st_d;
  logic [7:0] rdata_q, rdata_d;
  logic       hit_fifo, hit_stat, wr_fifo, pop, sh_busy, accept;
  logic [1:0] nbytes;

  // channel window decode: low five address bits ignored
  function automatic logic window_hit(input logic [6:0] a,
                                      input logic [6:0] base);
    return (a & stfs_pkg::ADDR_WIN_MASK) == base;
  endfunction

  assign hit_fifo = window_hit(addr, CHANNEL_B ? stfs_pkg::ADDR_FIFO_B
                                               : stfs_pkg::ADDR_FIFO_A); // RL7
  assign hit_stat = addr == (CHANNEL_B ? stfs_pkg::ADDR_STATUS_B
                                       : stfs_pkg::ADDR_STATUS_A);
  assign wr_fifo  = wr && hit_fifo;
  // storage is refused near full so a word write never overruns the array
  assign accept   = cnt_q < (stfs_pkg::PTR_W+1)'(DEPTH - 1);

  // in dma mode the final word of an odd count carries one byte only
  always_comb begin
    nbytes = word_mode ? 2'd2 : 2'd1; // RL1
    if (dma_select && word_mode && rem_q == 12'd1)
      nbytes = 2'd1; // RL5
  end

  assign pop = !sh_busy && cnt_q != '0;

  stfs_shifter u_shift (
    .mclk      (mclk),
    .rst       (rst),
    .tx_clk_en (tx_clk_en),
    .load      (pop),
    .data      (mem_q[rp_q]),
    .busy      (sh_busy),
    .txd       (txd)
  );

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    ovf_d = ovf_q;
    if (pop) begin
      rp_d = rp_q + 1'b1;
      cnt_d = cnt_d - 1'b1;
    end
    if (wr_fifo && accept) begin
      wp_d  = wp_q + (stfs_pkg::PTR_W)'(nbytes);
      cnt_d = cnt_d + (stfs_pkg::PTR_W+1)'(nbytes);
    end
    // refused writes still count, otherwise overflow could never show
    if (wr_fifo && acc_q <= (stfs_pkg::PTR_W+1)'(stfs_pkg::HALF_BYTES))
      acc_d = acc_q + (stfs_pkg::PTR_W+1)'(nbytes);
    // accessible half drained into the inaccessible half once count fits
    if (cnt_d <= (stfs_pkg::PTR_W+1)'(stfs_pkg::HALF_BYTES))
      acc_d = '0;
    if (acc_d > (stfs_pkg::PTR_W+1)'(stfs_pkg::HALF_BYTES))
      ovf_d = 1'b1; // RL8
    else if (acc_d == '0)
      ovf_d = 1'b0; // RL9
    if (tx_reset_cmd) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
      acc_d = '0;
      ovf_d = 1'b0; // RL9
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_fifo && accept) begin
      mem_q[wp_q] <= wdata[7:0];
      if (nbytes == 2'd2)
        mem_q[wp_q + 1'b1] <= wdata[15:8];
    end
  end

  // interrupt mode: ready pulses when the accessible half is empty
  always_comb begin
    rdy_d = !dma_select && acc_d == '0 && acc_q != '0; // RL2 RL3
    if (tx_reset_cmd && !dma_select)
      rdy_d = 1'b1;
  end

  // dma block sequencer: blocks of 32 bytes or 16 words, then the rest
  always_comb begin
    st_d = st_q;
    rem_d = rem_q;
    blk_d = blk_q;
    case (st_q)
      stfs_pkg::STFS_IDLE: begin
        if (transmit_frame_cmd && dma_select && tx_byte_count != '0) begin
          rem_d = tx_byte_count; // RL4
          st_d = stfs_pkg::STFS_WAIT;
        end
      end
      stfs_pkg::STFS_WAIT: begin
        if (acc_q == '0 && !wr_fifo) begin
          blk_d = word_mode ? 6'(stfs_pkg::WORD_BLOCK)
                            : 6'(stfs_pkg::HALF_BYTES); // RL6
          st_d = stfs_pkg::STFS_BLOCK;
        end
      end
      stfs_pkg::STFS_BLOCK: begin
        if (wr_fifo) begin
          rem_d = (rem_q > 12'(nbytes)) ? rem_q - 12'(nbytes) : 12'd0;
          blk_d = blk_q - 6'd1;
          if (rem_d == '0)
            st_d = stfs_pkg::STFS_IDLE; // RL6
          else if (blk_q == 6'd1)
            st_d = stfs_pkg::STFS_WAIT;
        end
      end
      default: st_d = stfs_pkg::STFS_IDLE;
    endcase
    if (tx_reset_cmd || !dma_select)
      st_d = stfs_pkg::STFS_IDLE; // RL2
  end

  // command execution: one tx period (two half periods) per step, held in power-down
  always_comb begin
    cec_d = cec_q;
    ceccnt_d = ceccnt_q;
    if (cmd_write && !cec_q) begin // RL14 RL15
      cec_d = 1'b1;
      ceccnt_d = 3'(stfs_pkg::CMD_HALF_PERIODS - 1);
    end else if (cec_q && !power_down && tx_clk_en) begin // RL17
      if (ceccnt_q <= 3'd2)
        cec_d = 1'b0; // RL16
      else
        ceccnt_d = ceccnt_q - 3'd2;
    end
  end

  always_comb begin
    sync_d = sync_q;
    if (sync_char_found)
      sync_d = 1'b1; // RL13
    else if (resync_search_cmd)
      sync_d = 1'b0; // RL12
  end

  always_comb begin
    rdata_d = rdata_q;
    if (rd && hit_stat) begin
      rdata_d = 8'h00; // RL18
      rdata_d[stfs_pkg::BIT_OVF]  = ovf_q;
      rdata_d[stfs_pkg::BIT_WREN] = acc_q == '0 && !ovf_q; // RL10
      rdata_d[stfs_pkg::BIT_RXNE] = rx_fifo_not_empty; // RL11
      rdata_d[stfs_pkg::BIT_SYNC] = sync_q;
      rdata_d[stfs_pkg::BIT_CEC]  = cec_q || power_down; // RL17
      rdata_d[stfs_pkg::BIT_CTS]  = !cts_n; // RL18
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      acc_q <= '0;
      ovf_q <= 1'b0;
      rdy_q <= 1'b0;
      st_q <= stfs_pkg::STFS_IDLE;
      rem_q <= '0;
      blk_q <= '0;
      cec_q <= 1'b0;
      ceccnt_q <= '0;
      sync_q <= 1'b0;
      rdata_q <= stfs_pkg::STATUS_RESET;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      ovf_q <= ovf_d;
      rdy_q <= rdy_d;
      st_q <= st_d;
      rem_q <= rem_d;
      blk_q <= blk_d;
      cec_q <= cec_d;
      ceccnt_q <= ceccnt_d;
      sync_q <= sync_d;
      rdata_q <= rdata_d;
    end
  end

  assign tx_pool_ready_irq = rdy_q;
  assign dma_request = st_q == stfs_pkg::STFS_BLOCK; // RL6
  assign rdata = rdata_q;
endmodule // stfs_core

// ---- stfs_core_props.sv ----
// stfs_core_props: port-level checks for one channel of stfs_core.
// assumes a bind to stfs_core; status read data lands one cycle after rd.
`timescale 1ns/1ps
module stfs_core_props #(
  parameter logic CHANNEL_B = 1'b0
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [6:0] addr,
  input wire logic       rd,
  input wire logic       dma_select,
  input wire logic       power_down,
  input wire logic       rx_fifo_not_empty,
  input wire logic       sync_char_found,
  input wire logic       resync_search_cmd,
  input wire logic       cts_n,
  input wire logic [7:0] rdata,
  input wire logic       dma_request
);
  logic st;
  assign st = rd && addr == (CHANNEL_B ? stfs_pkg::ADDR_STATUS_B
                                       : stfs_pkg::ADDR_STATUS_A);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_zero_bits: assert property (!rdata[3] && !rdata[0])
    else $error("unused status bits read as one");
  chk_cts_level: assert property (st |=> rdata[1] == !$past(cts_n))
    else $error("clear-to-send bit wrong");
  chk_rxne_level: assert property
    (st |=> rdata[5] == $past(rx_fifo_not_empty))
    else $error("rx not empty bit wrong");
  chk_ovf_wren: assert property (rdata[7] |-> !rdata[6])
    else $error("write enable shown during overflow");
  chk_pd_busy: assert property (st && power_down |=> rdata[2])
    else $error("command bit low in power-down");
  chk_sync_set: assert property (st && $past(sync_char_found, 2) &&
    !$past(resync_search_cmd) |=> rdata[4])
    else $error("sync bit not set after detect");
  chk_resync_search_cmd_clear: assert property (st && $past(resync_search_cmd, 2) &&
    !$past(sync_char_found, 2) && !$past(sync_char_found) |=> !rdata[4])
    else $error("sync bit not cleared by search");
  chk_no_dma_req: assert property (!dma_select [*2] |-> !dma_request)
    else $error("dma request in interrupt mode");
  cover property (st && power_down);
  cover property ($rose(dma_request));
  cover property (rdata[7]);
endmodule // stfs_core_props

// ---- stfs_line_model.sv ----
// stfs_line_model: transmit clock source and serial line monitor.
// assumes one tx_clk_en pulse per bit period; clock stands while run is low.
`timescale 1ns/1ps
module stfs_line_model (
  input wire logic   mclk,
  input wire logic   rst,
  input wire logic   run,
  input wire logic   txd,
  output logic        tx_clk_en,
  output logic [63:0] line_bits
);
  logic [1:0] div_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
      tx_clk_en <= 1'b0;
      line_bits <= '1;
    end else begin
      div_q <= run ? div_q + 2'h1 : 2'h0;
      tx_clk_en <= run && div_q == 2'h3;
      // newest sample enters at the top, so the first bit ends lowest
      if (tx_clk_en)
        line_bits <= {txd, line_bits[63:1]};
    end
  end
endmodule // stfs_line_model

// ---- tb.sv ----
// tb: self-checking bench for channel a of the transmit fifo block.
// assumes stfs_core with default channel and stfs_line_model as tx clock.
`timescale 1ns/1ps
module tb;
  logic mclk, rst, wr, rd, word_mode, dma_select, transmit_frame_cmd;
  logic tx_reset_cmd, resync_search_cmd, cmd_write, power_down, run;
  logic tx_clk_en, rx_fifo_not_empty, sync_char_found, cts_n, txd;
  logic tx_pool_ready_irq, dma_request;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic [7:0]  rdata;
  logic [11:0] tx_byte_count;
  logic [63:0] line_bits;
  int          bad_count, compares;
  stfs_core dut_u (.mclk, .rst, .addr, .wr, .rd, .word_mode, .wdata, .rdata,
    .dma_select, .tx_byte_count, .transmit_frame_cmd, .tx_reset_cmd,
    .resync_search_cmd, .cmd_write, .power_down, .tx_clk_en,
    .rx_fifo_not_empty, .sync_char_found, .cts_n, .tx_pool_ready_irq,
    .dma_request, .txd);
  stfs_line_model line_u (.mclk, .rst, .run, .txd, .tx_clk_en, .line_bits);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic write(input logic [6:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    pulse(wr);
  endtask
  // read stays high one edge; rdata is looked at a full cycle later
  task automatic status(input logic [7:0] mask, input logic [7:0] exp);
    addr = stfs_pkg::ADDR_STATUS_A;
    pulse(rd);
    check(rdata & mask, exp);
  endtask
  function automatic logic found_a5();
    for (int i = 0; i < 48; i++)
      if (line_bits[i+:8] == 8'ha5 || line_bits[i+:16] == 16'hcc33)
        return 1'b1;
    return 1'b0;
  endfunction
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {wr, rd, word_mode, dma_select, transmit_frame_cmd, tx_reset_cmd} = '0;
    {resync_search_cmd, cmd_write, power_down, run} = '0;
    {rx_fifo_not_empty, sync_char_found, addr, wdata, tx_byte_count} = '0;
    cts_n = 1'b1;
    bad_count = 0;
    compares = 0;
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(1);
    status(8'hff, 8'h40);
    cts_n = 1'b0;
    rx_fifo_not_empty = 1'b1;
    status(8'hff, 8'h62);
    cts_n = 1'b1;
    rx_fifo_not_empty = 1'b0;
    // shifter stalled: the first byte loads the shifter, the next 32 fill the hidden half, the rest stay visible
    for (int i = 0; i < 65; i++)
      write({2'h0, i[4:0]}, {8'h00, i[7:0]});
    status(8'hc0, 8'h00);
    write(7'h1f, 16'h0077);
    status(8'hc0, 8'h80);
    tx_reset_cmd = 1'b1;
    cyc(1);
    check(tx_pool_ready_irq, 1'b1);
    tx_reset_cmd = 1'b0;
    cyc(1);
    check(tx_pool_ready_irq, 1'b0);
    status(8'hff, 8'h40);
    write(7'h05, 16'h00a5);
    run = 1'b1;
    cyc(200);
    check(found_a5(), 1'b1);
    check(txd, 1'b1);
    run = 1'b0;
    pulse(cmd_write);
    status(8'h04, 8'h04);
    run = 1'b1;
    cyc(30);
    status(8'h04, 8'h00);
    power_down = 1'b1;
    pulse(cmd_write);
    cyc(40);
    status(8'h04, 8'h04);
    power_down = 1'b0;
    cyc(30);
    pulse(sync_char_found);
    status(8'h10, 8'h10);
    pulse(resync_search_cmd);
    status(8'h10, 8'h00);
    run = 1'b0;
    pulse(tx_reset_cmd);
    dma_select = 1'b1;
    word_mode = 1'b1;
    tx_byte_count = 12'h003;
    pulse(transmit_frame_cmd);
    for (int i = 0; i < 200 && dma_request !== 1'b1; i++)
      cyc(1);
    check(dma_request, 1'b1);
    if (dma_request !== 1'b1)
      finish_test();
    write(7'h00, 16'h2211);
    write(7'h00, 16'h0033);
    cyc(3);
    check(dma_request, 1'b0);
    dma_select = 1'b0;
    cyc(3);
    check(dma_request, 1'b0);
    finish_test();
  end
endmodule // tb
bind stfs_core stfs_core_props #(.CHANNEL_B(CHANNEL_B)) props_u (.mclk,
  .rst, .addr, .rd, .dma_select, .power_down, .rx_fifo_not_empty,
  .sync_char_found, .resync_search_cmd, .cts_n, .rdata, .dma_request);
